/* File: rtl/tec_pkg.sv */
package tec_pkg;

    // system clock and derived rates
    localparam int CLK_HZ         = 25_000_000;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int DEBOUNCE_MS    = 10;
    localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * 1000 + TICK_US - 1) / TICK_US;

    // autozero capture window, percent of rated output
    localparam int AZ_WINDOW_PCT  = 10;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

    // control fields
    localparam int CTRL_POLICY_LSB = 0;
    localparam int CTRL_SWCLR_BIT  = 2;

    // status fields
    localparam int STAT_LIGHT_LSB  = 0;
    localparam int STAT_FAULT_BIT  = 2;
    localparam int STAT_AZ_BIT     = 3;
    localparam int STAT_SET2_BIT   = 4;
    localparam int STAT_SEL_BIT    = 5;
    localparam int STAT_ERRNOW_BIT = 6;

    // interrupt event bits
    localparam int IRQ_W          = 4;
    localparam int IRQ_FAULT_BIT  = 0;
    localparam int IRQ_LIGHT_BIT  = 1;
    localparam int IRQ_AZREJ_BIT  = 2;
    localparam int IRQ_AZCHG_BIT  = 3;

    // reset values
    localparam logic [1:0]       POLICY_RST = 2'h0;
    localparam logic [IRQ_W-1:0] MASK_RST   = 4'h0;

    // calibration selection policy codes
    localparam logic [1:0] POLICY_EXT  = 2'h0;
    localparam logic [1:0] POLICY_SET1 = 2'h1;
    localparam logic [1:0] POLICY_SET2 = 2'h2;

    // received light grades
    localparam logic [1:0] LIGHT_NORMAL = 2'h0;
    localparam logic [1:0] LIGHT_LOW    = 2'h1;
    localparam logic [1:0] LIGHT_INSUF  = 2'h2;

    typedef enum logic {
        TEC_AZ_IDLE,
        TEC_AZ_HOLD
    } tec_az_state_t;

endpackage

/* File: rtl/tec_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// free running divider giving a one-cycle enable every DIV cycles
module tec_tick #(
    parameter int DIV = 25000
) (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;

    // wrap at DIV-1, pulse on the wrap
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/tec_debounce.sv */
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser then a stable-for-n-ticks filter;
// pin_n low (shorted to return) means asserted
module tec_debounce #(
    parameter int TICKS = 10
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic tick,
    input  wire logic pin_n,
    output logic      asserted
);
    localparam int CW = $clog2(TICKS + 1);

    logic          meta_q;
    logic          sync_q;
    logic [CW-1:0] cnt_q;

    // first flop feeds only the second; reset to open (not asserted)
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_n;
            sync_q <= meta_q;
        end
    end

    // output follows only after TICKS agreeing samples
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q    <= '0;
            asserted <= 1'b0;
        end else if (asserted == !sync_q) begin
            cnt_q <= '0;
        end else if (tick) begin
            if (cnt_q == CW'(TICKS - 1)) begin
                cnt_q    <= '0;
                asserted <= !sync_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: rtl/tec_ctrl_io.sv */
// Summary of operation
// - first alarm low while light is normal
// - second alarm low at low light
// - third alarm low at insufficient light
// - fault low on any error or light error
// - fault-clear input cancels error status
// - policy 0: select open set1, shorted set2
// - policy 1 or 2 forces set, ignores select
// - capture zeroes output only within ten percent
// - release acts only while autozero active
// - error latched until cause gone and cancelled
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tec_ctrl_io
    import tec_pkg::*;
#(
    parameter int          TICK_DIV     = TICK_CYCLES,
    parameter int          DB_TICKS     = DEBOUNCE_TICKS,
    parameter int          ERR_W        = 8,
    parameter int          TW           = 16,
    parameter logic [15:0] TORQUE_RATED = 16'h4E20
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output logic      [31:0]   rdata,
    output logic               irq,
    input  wire logic          sel_n,
    input  wire logic          zero_cap_n,
    input  wire logic          zero_rel_n,
    input  wire logic          fault_clr_n,
    input  wire logic [1:0]    light_level,
    input  wire logic [ERR_W-1:0] err_src,
    input  wire logic signed [TW-1:0] torque_in,
    output logic               alarm_normal_n,
    output logic               alarm_low_n,
    output logic               alarm_insuf_n,
    output logic               fault_n,
    output logic               cal_set2,
    output logic               az_active,
    output logic signed [TW-1:0] torque_out
);

    // magnitude of a signed sample, one bit wider so the most
    // negative code does not wrap
    function automatic logic [TW:0] mag(input logic signed [TW-1:0] v);
        logic signed [TW:0] w;
        w = {v[TW-1], v};
        mag = w[TW] ? -w : w;
    endfunction

    // true when |v| * 100 <= rated * pct
    function automatic logic in_window(input logic signed [TW-1:0] v);
        logic [TW+7:0] lhs;
        logic [TW+7:0] rhs;
        lhs = (TW+8)'(mag(v)) * (TW+8)'(100);
        rhs = (TW+8)'(TORQUE_RATED) * (TW+8)'(AZ_WINDOW_PCT);
        in_window = (lhs <= rhs);
    endfunction

    // ------------------------------------------------------------
    // slow enable and input conditioning
    // ------------------------------------------------------------
    logic tick;

    tec_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );

    logic sel_on;
    logic cap_on;
    logic rel_on;
    logic clr_on;

    // contacts bounce; each input is synchronised and filtered
    tec_debounce #(.TICKS(DB_TICKS)) u_db_sel (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tick),
        .pin_n    (sel_n),   // low = shorted to return
        .asserted (sel_on)
    );

    tec_debounce #(.TICKS(DB_TICKS)) u_db_cap (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tick),
        .pin_n    (zero_cap_n),
        .asserted (cap_on)
    );

    tec_debounce #(.TICKS(DB_TICKS)) u_db_rel (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tick),
        .pin_n    (zero_rel_n),
        .asserted (rel_on)
    );

    tec_debounce #(.TICKS(DB_TICKS)) u_db_clr (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tick),
        .pin_n    (fault_clr_n),
        .asserted (clr_on)
    );

    // previous levels for asserting-edge detection
    logic cap_q;
    logic rel_q;
    logic clr_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cap_q <= 1'b0;
            rel_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            cap_q <= cap_on;
            rel_q <= rel_on;
            clr_q <= clr_on;
        end
    end

    // a held contact acts once, not every cycle
    logic cap_evt;
    logic rel_evt;
    logic clr_evt;

    assign cap_evt = cap_on & ~cap_q;
    assign rel_evt = rel_on & ~rel_q;
    assign clr_evt = clr_on & ~clr_q;

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic [1:0]       policy_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic             sw_clr;

    logic wr_ctrl;
    logic wr_mask;
    logic rd_irq;

    assign wr_ctrl = wr_en && (addr == REG_CTRL);
    assign wr_mask = wr_en && (addr == REG_IRQ_MASK);
    assign rd_irq  = rd_en && (addr == REG_IRQ_STAT);
    assign sw_clr  = wr_ctrl && wdata[CTRL_SWCLR_BIT];

    // calibration policy; clear bit is a self-clearing strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            policy_q <= POLICY_RST;
        end else if (wr_ctrl) begin
            policy_q <= wdata[CTRL_POLICY_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_mask_q <= MASK_RST;
        end else if (wr_mask) begin
            irq_mask_q <= wdata[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // light grade alarms
    // ------------------------------------------------------------
    logic [1:0] light_q;

    // open-collector alarms: low = transistor on
    always_ff @(posedge clk) begin
        if (!rstn) begin
            light_q        <= LIGHT_NORMAL;
            alarm_normal_n <= 1'b1;
            alarm_low_n    <= 1'b1;
            alarm_insuf_n  <= 1'b1;
        end else begin
            light_q        <= light_level;
            alarm_normal_n <= !(light_level == LIGHT_NORMAL);
            alarm_low_n    <= !(light_level == LIGHT_LOW);
            alarm_insuf_n  <= !(light_level == LIGHT_INSUF);
        end
    end

    // ------------------------------------------------------------
    // error latch
    // ------------------------------------------------------------
    logic err_now;
    logic err_q;
    logic err_set;
    logic err_cancel;

    // any listed error source or the light error counts
    assign err_now    = (|err_src) || (light_level == LIGHT_INSUF);
    assign err_set    = err_now & ~err_q;
    // cancel only once the cause has gone
    assign err_cancel = (clr_evt | sw_clr) & ~err_now;

    // set wins; cancel by input or software only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            err_q <= 1'b0;
        end else if (err_now) begin
            err_q <= 1'b1;
        end else if (err_cancel) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fault_n <= 1'b1;
        end else begin
            fault_n <= !(err_q | err_now);
        end
    end

    // ------------------------------------------------------------
    // calibration set selection
    // ------------------------------------------------------------
    // code 3 is undefined; it behaves as external select
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cal_set2 <= 1'b0;
        end else begin
            case (policy_q)
                POLICY_SET1: cal_set2 <= 1'b0;
                POLICY_SET2: cal_set2 <= 1'b1;
                default:     cal_set2 <= sel_on;
            endcase
        end
    end

    // ------------------------------------------------------------
    // autozero
    // ------------------------------------------------------------
    tec_az_state_t    az_state_q;
    logic signed [TW-1:0] az_offset_q;
    logic             az_reject;
    logic             az_change;
    logic             az_ok;

    assign az_ok     = in_window(TW'(torque_in - az_offset_q));
    assign az_reject = cap_evt & ~az_ok;

    // an accepted capture wins if both edges land together; the window is judged
    // on the present output, so a re-zero while holding tests torque less the held offset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            az_state_q  <= TEC_AZ_IDLE;
            az_offset_q <= '0;
            az_change   <= 1'b0;
        end else begin
            az_change <= 1'b0;
            case (az_state_q)
                TEC_AZ_IDLE: begin
                    if (cap_evt && az_ok) begin
                        az_state_q  <= TEC_AZ_HOLD;
                        az_offset_q <= torque_in;
                        az_change   <= 1'b1;
                    end
                end
                TEC_AZ_HOLD: begin
                    if (cap_evt && az_ok) begin
                        az_offset_q <= torque_in;
                        az_change   <= 1'b1;
                    end else if (rel_evt) begin
                        az_state_q  <= TEC_AZ_IDLE;
                        az_offset_q <= '0;
                        az_change   <= 1'b1;
                    end
                end
                default: begin
                    az_state_q  <= TEC_AZ_IDLE;
                    az_offset_q <= '0;
                end
            endcase
        end
    end

    // output follows torque, less the captured zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            az_active  <= 1'b0;
            torque_out <= '0;
        end else begin
            az_active  <= (az_state_q == TEC_AZ_HOLD);
            torque_out <= TW'(torque_in - az_offset_q);
        end
    end

    // ------------------------------------------------------------
    // interrupt status, read-to-clear, set wins over clear
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_evt;

    always_comb begin
        irq_evt                = '0;
        irq_evt[IRQ_FAULT_BIT] = err_set;
        irq_evt[IRQ_LIGHT_BIT] = (light_level != light_q);
        irq_evt[IRQ_AZREJ_BIT] = az_reject;
        irq_evt[IRQ_AZCHG_BIT] = az_change;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_q <= '0;
        end else if (rd_irq) begin
            irq_stat_q <= irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    // level output, registered so it lags status by one cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // read data, valid the cycle after the strobe
    // ------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word                          = '0;
        status_word[STAT_LIGHT_LSB +: 2]     = light_q;
        status_word[STAT_FAULT_BIT]          = err_q;
        status_word[STAT_AZ_BIT]             = (az_state_q == TEC_AZ_HOLD);
        status_word[STAT_SET2_BIT]           = cal_set2;
        status_word[STAT_SEL_BIT]            = sel_on;
        status_word[STAT_ERRNOW_BIT]         = err_now;
    end

    // unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (rd_en) begin
            case (addr)
                REG_CTRL:     rdata <= {30'h0000_0000, policy_q};
                REG_STATUS:   rdata <= status_word;
                REG_IRQ_STAT: rdata <= {28'h000_0000, irq_stat_q};
                REG_IRQ_MASK: rdata <= {28'h000_0000, irq_mask_q};
                default:      rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

endmodule

`default_nettype wire

/* File: verif/tec_ctrl_io_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module tec_ctrl_io_properties
    import tec_pkg::*;
#(
    parameter int          ERR_W        = 8,
    parameter int          TW           = 16,
    parameter logic [15:0] TORQUE_RATED = 16'h4E20
) (
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire logic [7:0]           addr,
    input wire logic [31:0]          wdata,
    input wire logic                 wr_en,
    input wire logic [1:0]           light_level,
    input wire logic [ERR_W-1:0]     err_src,
    input wire logic signed [TW-1:0] torque_in,
    input wire logic                 fault_clr_n,
    input wire logic                 alarm_normal_n,
    input wire logic                 alarm_low_n,
    input wire logic                 alarm_insuf_n,
    input wire logic                 fault_n,
    input wire logic                 cal_set2,
    input wire logic                 az_active,
    input wire logic signed [TW-1:0] torque_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // shadow of the policy field, changed only by a control write
    logic [1:0] pol_q;
    wire logic  sw_clr = wr_en && addr == REG_CTRL && wdata[CTRL_SWCLR_BIT];
    wire logic  err_on = err_src != '0 || light_level == LIGHT_INSUF;
    always_ff @(posedge clk) begin
        if (!rstn)
            pol_q <= POLICY_RST;
        else if (wr_en && addr == REG_CTRL)
            pol_q <= wdata[1:0];
    end

    // capture window test done in integers so the sign never wraps
    function automatic bit in_win(logic signed [TW-1:0] t);
        int a;
        a = (t < 0) ? -int'(t) : int'(t);
        return a * 100 <= int'(TORQUE_RATED) * AZ_WINDOW_PCT;
    endfunction

    sequence steady_s;
        $stable(torque_in) [*4];
    endsequence
    // pin quiet long enough that no debounced clear edge is in flight
    sequence clr_quiet_s;
        fault_clr_n [*6];
    endsequence

    chk_alarm_normal: assert property (
        $past(rstn) |=> alarm_normal_n == ($past(light_level) != LIGHT_NORMAL))
        else $error("alarm_normal_n does not follow light level");
    chk_alarm_low: assert property (
        $past(rstn) |=> alarm_low_n == ($past(light_level) != LIGHT_LOW))
        else $error("alarm_low_n does not follow light level");
    chk_alarm_insuf: assert property (
        $past(rstn) |=> alarm_insuf_n == ($past(light_level) != LIGHT_INSUF))
        else $error("alarm_insuf_n does not follow light level");
    chk_fault_set: assert property (
        $past(rstn) && err_on |=> !fault_n)
        else $error("fault_n not low while an error is present");
    chk_fault_hold: assert property (
        clr_quiet_s ##0 (!fault_n && !sw_clr && !$past(sw_clr) && !$past(sw_clr, 2))
        |=> !fault_n)
        else $error("fault_n released without a cancel");
    chk_fault_cancel: assert property (
        sw_clr && !err_on ##1 (!err_on) [*3] |=> fault_n)
        else $error("fault_n not released by a cancel");
    chk_policy_forced: assert property (
        (pol_q == POLICY_SET1 || pol_q == POLICY_SET2) && $stable(pol_q)
        |-> cal_set2 == (pol_q == POLICY_SET2))
        else $error("cal_set2 does not follow the forcing policy");
    chk_az_idle: assert property (
        $past(rstn, 2) && $past(rstn) && !az_active |-> torque_out == $past(torque_in))
        else $error("torque_out not live while autozero idle");
    chk_az_zero: assert property (
        steady_s ##0 $rose(az_active) |-> torque_out == '0 && in_win(torque_in))
        else $error("autozero taken outside window or output not zero");
endmodule

bind tec_ctrl_io tec_ctrl_io_properties #(
    .ERR_W(ERR_W),
    .TW(TW),
    .TORQUE_RATED(TORQUE_RATED)
) tec_ctrl_io_properties_inst (
    .clk, .rstn, .addr, .wdata, .wr_en, .light_level, .err_src, .torque_in,
    .fault_clr_n, .alarm_normal_n, .alarm_low_n, .alarm_insuf_n, .fault_n,
    .cal_set2, .az_active, .torque_out
);

`default_nettype wire

/* File: verif/tec_contacts.sv */
`timescale 1ns/1ps
`default_nettype none

// contact bank of the external controller; an open line floats high on its pull-up
module tec_contacts #(
    parameter int BOUNCE = 3
) (
    input  wire logic       clk,
    input  wire logic [3:0] closed,
    output logic      [3:0] pins_n
);
    logic [3:0] last_q;
    int         chat_q [4];

    // every change of a contact chatters for a few cycles, as real contacts do
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            last_q[i] <= closed[i];
            if (closed[i] != last_q[i])
                chat_q[i] <= BOUNCE;
            else if (chat_q[i] > 0)
                chat_q[i] <= chat_q[i] - 1;
        end
    end

    // a closed contact shorts the line to the input return
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pins_n[i] = (chat_q[i] > 0) ? chat_q[i][0] : !closed[i];
        end
    end
endmodule

`default_nettype wire

/* File: verif/tb_transducer_ext_control_io.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_transducer_ext_control_io;
    import tec_pkg::*;
    localparam int          LIMIT = 5000;
    localparam logic [15:0] RATED = 16'h4E20;
    localparam int          WIN   = int'(RATED) * AZ_WINDOW_PCT / 100;
    localparam int          STEP  = 32'h0000_0064;

    logic               clk         = 1'b0;
    logic               rstn        = 1'b0;
    logic [7:0]         addr        = 8'h00;
    logic [31:0]        wdata       = 32'h0000_0000;
    logic               wr_en       = 1'b0;
    logic               rd_en       = 1'b0;
    logic [1:0]         light_level = 2'h0;
    logic [7:0]         err_src     = 8'h00;
    logic signed [15:0] torque_in   = 16'h0000;
    logic [3:0]         closed      = 4'h0;
    logic [31:0]        rng         = 32'h0001_2536;
    wire logic [3:0]    pins_n;
    wire logic [31:0]   rdata;
    wire logic          irq, alarm_normal_n, alarm_low_n, alarm_insuf_n;
    wire logic          fault_n, cal_set2, az_active;
    wire logic signed [15:0] torque_out;
    int                 fail_count  = 0;
    int                 check_count = 0;
    int                 cyc         = 0;

    // short divider and filter keep each contact action to a few dozen cycles
    tec_ctrl_io #(
        .TICK_DIV(4), .DB_TICKS(2), .ERR_W(8), .TW(16), .TORQUE_RATED(RATED)
    ) tec_ctrl_io_inst (
        .clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
        .sel_n(pins_n[0]), .zero_cap_n(pins_n[1]), .zero_rel_n(pins_n[2]),
        .fault_clr_n(pins_n[3]), .light_level, .err_src, .torque_in,
        .alarm_normal_n, .alarm_low_n, .alarm_insuf_n, .fault_n, .cal_set2,
        .az_active, .torque_out
    );
    tec_contacts tec_contacts_inst (.clk, .closed, .pins_n);

    always #20 clk = ~clk;

    // a hang counts as a mismatch and goes to the report
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic exp_set2(input int p, input logic s);
        return (p == POLICY_SET1) ? 1'b0 : (p == POLICY_SET2) ? 1'b1 : s;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // hold long enough for bounce, sync and filter to settle
    task automatic press(input int i, input logic v);
        @(posedge clk);
        closed[i] <= v;
        wait_cyc(40);
    endtask

    task automatic az_cycle(input int t, input logic ok);
        @(posedge clk);
        torque_in <= t[15:0];
        press(1, 1'b1);
        press(1, 1'b0);
        check("az_active capture", ok, az_active);
        check("torque_out zeroed", ok ? 0 : t, torque_out);
        @(posedge clk);
        torque_in <= t[15:0] + STEP[15:0];
        wait_cyc(3);
        check("torque_out track", ok ? STEP : t + STEP, torque_out);
        press(2, 1'b1);
        press(2, 1'b0);
        check("az_active release", 1'b0, az_active);
        check("torque_out live", t + STEP, torque_out);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        int          e;
        wait_cyc(8);
        rstn <= 1'b1;
        wait_cyc(2);
        reg_rd(REG_IRQ_MASK, d);
        check("mask reset", {28'h000_0000, MASK_RST}, d);
        reg_rd(REG_CTRL, d);
        check("ctrl reset", {30'h0000_0000, POLICY_RST}, d);
        reg_rd(8'h10, d);
        check("unmapped read", 32'h0000_0000, d);
        reg_wr(REG_IRQ_MASK, 32'h0000_0001 << IRQ_FAULT_BIT);
        for (int lv = 0; lv < 3; lv++) begin
            @(posedge clk);
            light_level <= lv[1:0];
            wait_cyc(3);
            check("alarm_normal_n", lv != 0, alarm_normal_n);
            check("alarm_low_n", lv != 1, alarm_low_n);
            check("alarm_insuf_n", lv != 2, alarm_insuf_n);
        end
        check("fault_n light", 1'b0, fault_n);
        check("irq raised", 1'b1, irq);
        reg_rd(REG_IRQ_STAT, d);
        check("irq status", 32'h0000_0003, d);
        wait_cyc(2);
        check("irq cleared", 1'b0, irq);
        // a clear with the error still present must leave the latch alone
        @(posedge clk);
        light_level <= LIGHT_NORMAL;
        rng = xorshift(rng);
        e = int'(rng[2:0]);
        err_src <= 8'h01 << e;
        press(3, 1'b1);
        press(3, 1'b0);
        check("fault_n held", 1'b0, fault_n);
        @(posedge clk);
        err_src <= 8'h00;
        wait_cyc(4);
        check("fault_n latched", 1'b0, fault_n);
        reg_wr(REG_CTRL, 32'h0000_0001 << CTRL_SWCLR_BIT);
        wait_cyc(3);
        check("fault_n sw cancel", 1'b1, fault_n);
        @(posedge clk);
        err_src <= 8'h01 << e;
        @(posedge clk);
        err_src <= 8'h00;
        wait_cyc(3);
        check("fault_n relatched", 1'b0, fault_n);
        press(3, 1'b1);
        check("fault_n pin clear", 1'b1, fault_n);
        press(3, 1'b0);
        // every policy code against both select levels
        for (int k = 0; k < 8; k++) begin
            reg_wr(REG_CTRL, k >> 1);
            press(0, k[0]);
            check("cal_set2", exp_set2(k >> 1, k[0]), cal_set2);
            reg_rd(REG_STATUS, d);
            check("status set2", exp_set2(k >> 1, k[0]), d[STAT_SET2_BIT]);
        end
        press(0, 1'b0);
        rng = xorshift(rng);
        az_cycle(int'(rng % (2 * WIN + 1)) - WIN, 1'b1);
        az_cycle(-WIN, 1'b1);
        az_cycle(WIN + 1, 1'b0);
        reg_rd(REG_IRQ_STAT, d);
        check("capture rejected", 1'b1, d[IRQ_AZREJ_BIT]);
        tally_and_finish();
    end
endmodule

`default_nettype wire
